// *** design/ocec_pkg.sv ***
// package: register map, field layout and reset values of the output enable block
//
// What this block does
// - a read-write global output-enable bit sits at bit 12 of the output driver control word and resets to 1.
// - each per-output disable bit is read-write, 0 leaves the driver enabled and 1 forces it disabled.
// - a differential output with its disable bit set has both its true and complement drivers turned off.
// - a single-ended output with its disable bit set has its single driver turned off.
// - a cleared disable bit never forces a driver on; other disable sources still turn it off.
// - disable bits 11 down to 5 steer the output of the same index and reset to 0.
// - disable bits 4 down to 0 behave the same for outputs 4 to 0 and reset to 0.
package ocec_pkg;
	localparam int OCEC_NUM_OUT = 12;
	localparam int OCEC_ADDR_W = 4;
	localparam int OCEC_DATA_W = 32;
	localparam int OCEC_CTRL_W = 16;
	// word offsets (byte addresses)
	localparam logic [OCEC_ADDR_W-1:0] OCEC_OFS_CTRL = 4'h0;
	localparam logic [OCEC_ADDR_W-1:0] OCEC_OFS_MODE = 4'h4;
	localparam logic [OCEC_ADDR_W-1:0] OCEC_OFS_STAT = 4'h8;
	// field positions in the control word
	localparam int OCEC_GOE_BIT = 12;
	localparam int OCEC_DIS_LSB = 0;
	// reset values
	localparam logic OCEC_GOE_RST = 1'h1;
	localparam logic [OCEC_NUM_OUT-1:0] OCEC_DIS_RST = 12'h000;
	localparam logic [OCEC_NUM_OUT-1:0] OCEC_MODE_RST = 12'h000;
	localparam logic [OCEC_DATA_W-1:0] OCEC_UNMAPPED_RD = 32'h0000_0000;
endpackage

// *** design/ocec_drv_gate.sv ***
// module: per-output enable gating for true and complement drivers
`timescale 1ns/1ps
module ocec_drv_gate
	import ocec_pkg::*;
(
	input wire logic sys_clk, // system clock
	input wire logic rst_b, // sync reset, active low
	input wire logic global_en, // global output enable
	input wire logic out_disable, // this output's disable bit
	input wire logic ext_disable, // other disable source
	input wire logic diff_mode, // 1 differential, 0 single-ended
	output logic clock_true_pin_en, // true driver enable
	output logic clock_complement_pin_en // complement driver enable
);
	logic eff_en;

	// combined enable; a clear disable bit only permits, never forces on
	assign eff_en = global_en & ~out_disable & ~ext_disable;

	// registered so driver enables never glitch on bus writes
	always_ff @(posedge sys_clk)
	begin
		if (!rst_b)
		begin
			clock_true_pin_en <= 1'b0;
			clock_complement_pin_en <= 1'b0;
		end
		else
		begin
			clock_true_pin_en <= eff_en;
			clock_complement_pin_en <= eff_en & diff_mode;
		end
	end
endmodule

// *** design/ocec_top.sv ***
// module: output enable control register bank with avalon-mm slave
`timescale 1ns/1ps
module ocec_top
	import ocec_pkg::*;
(
	input wire logic sys_clk, // 100 mhz system clock
	input wire logic rst_b, // sync reset, active low
	input wire logic [ocec_pkg::OCEC_ADDR_W-1:0] avs_address, // byte address
	input wire logic avs_read, // read strobe
	input wire logic avs_write, // write strobe
	input wire logic [ocec_pkg::OCEC_DATA_W-1:0] avs_writedata, // write data
	input wire logic [3:0] avs_byteenable, // byte lanes
	output logic [ocec_pkg::OCEC_DATA_W-1:0] avs_readdata, // read data, registered
	output logic avs_waitrequest, // stall
	input wire logic [ocec_pkg::OCEC_NUM_OUT-1:0] ext_disable, // other disable sources
	output logic [ocec_pkg::OCEC_NUM_OUT-1:0] clock_true_pin_en, // true driver enables
	output logic [ocec_pkg::OCEC_NUM_OUT-1:0] clock_complement_pin_en // complement driver enables
);
	import ocec_pkg::*;

	typedef enum logic [1:0] {
		OCEC_IDLE = 2'b01,
		OCEC_DONE = 2'b10
	} ocec_state_e;

	ocec_state_e state_q;
	logic goe_q;
	logic [OCEC_NUM_OUT-1:0] dis_q;
	logic [OCEC_NUM_OUT-1:0] mode_q;
	logic req;
	logic wr_en;
	logic [OCEC_CTRL_W-1:0] ctrl_new;
	logic [OCEC_CTRL_W-1:0] mode_new;

	// merge 16 bits of new data under byte enables
	function automatic logic [OCEC_CTRL_W-1:0] merge16(input logic [OCEC_CTRL_W-1:0] old_v,
		input logic [OCEC_DATA_W-1:0] wd, input logic [3:0] be);
		logic [OCEC_CTRL_W-1:0] r;
		r = old_v;
		if (be[0])
			r[7:0] = wd[7:0];
		if (be[1])
			r[15:8] = wd[15:8];
		return r;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// bus handshake: one wait cycle, answer on the second edge
	assign req = avs_read | avs_write;
	assign avs_waitrequest = req & (state_q == OCEC_IDLE);
	// write lands only at the edge that sees waitrequest low, as the master expects
	assign wr_en = avs_write & (state_q == OCEC_DONE);

	// merged words; a function result cannot be indexed in place
	assign ctrl_new = merge16({3'h0, goe_q, dis_q}, avs_writedata, avs_byteenable);
	assign mode_new = merge16({4'h0, mode_q}, avs_writedata, avs_byteenable);

	always_ff @(posedge sys_clk)
	begin
		if (!rst_b)
			state_q <= OCEC_IDLE;
		else
		begin
			unique case (state_q)
				OCEC_IDLE:
					if (req)
						state_q <= OCEC_DONE;
				OCEC_DONE:
					state_q <= OCEC_IDLE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// control word: global enable and per-output disables
	always_ff @(posedge sys_clk)
	begin
		if (!rst_b)
		begin
			goe_q <= OCEC_GOE_RST;
			dis_q <= OCEC_DIS_RST;
		end
		else if (wr_en && avs_address == OCEC_OFS_CTRL)
		begin
			goe_q <= ctrl_new[OCEC_GOE_BIT];
			dis_q <= ctrl_new[OCEC_DIS_LSB +: OCEC_NUM_OUT];
		end
	end

	// driver format per output: 1 differential, 0 single-ended cmos
	always_ff @(posedge sys_clk)
	begin
		if (!rst_b)
			mode_q <= OCEC_MODE_RST;
		else if (wr_en && avs_address == OCEC_OFS_MODE)
			mode_q <= mode_new[OCEC_NUM_OUT-1:0];
	end

	////////////////////////////////////////////////////////////////////////
	// read data captured on the stall cycle; reserved bits read zero
	always_ff @(posedge sys_clk)
	begin
		if (!rst_b)
			avs_readdata <= OCEC_UNMAPPED_RD;
		else if (avs_read && state_q == OCEC_IDLE)
		begin
			unique case (avs_address)
				OCEC_OFS_CTRL:
					avs_readdata <= {19'h0_0000, goe_q, dis_q};
				OCEC_OFS_MODE:
					avs_readdata <= {20'h0_0000, mode_q};
				OCEC_OFS_STAT:
					avs_readdata <= {4'h0, clock_complement_pin_en, 4'h0, clock_true_pin_en};
				default:
					avs_readdata <= OCEC_UNMAPPED_RD;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// one gate per output, indexed to match its disable bit
	for (genvar i = 0; i < OCEC_NUM_OUT; i++)
	begin : g_out
		ocec_drv_gate u_gate (
			.sys_clk(sys_clk),
			.rst_b(rst_b),
			.global_en(goe_q),
			.out_disable(dis_q[i]),
			.ext_disable(ext_disable[i]),
			.diff_mode(mode_q[i]),
			.clock_true_pin_en(clock_true_pin_en[i]),
			.clock_complement_pin_en(clock_complement_pin_en[i])
		);
	end
endmodule

// *** sim/ocec_top_checker.sv ***
// checker: port-level properties of the output enable bank
`timescale 1ns/1ps
module ocec_top_checker
(
	input wire logic sys_clk, // clock
	input wire logic rst_b, // reset
	input wire logic [3:0] avs_address, // address
	input wire logic avs_read, // read
	input wire logic avs_write, // write
	input wire logic [31:0] avs_writedata, // wdata
	input wire logic [3:0] avs_byteenable, // lanes
	input wire logic [31:0] avs_readdata, // rdata
	input wire logic avs_waitrequest, // stall
	input wire logic [11:0] ext_disable, // other
	input wire logic [11:0] clock_true_pin_en, // true
	input wire logic [11:0] clock_complement_pin_en // comp
);
	default clocking @(posedge sys_clk);
	endclocking
	default disable iff (!rst_b);
	// a finished control write sets the true enables two cycles on
	a_write_apply: assert property (avs_write && !avs_waitrequest && avs_address == 4'h0 && avs_byteenable[1:0] == 2'h3
		|-> ##2 clock_true_pin_en == ({12{$past(avs_writedata[12], 2)}} & ~$past(avs_writedata[11:0], 2)
		& ~$past(ext_disable)))
		else $error("write not applied");
	a_pair_off: assert property ((clock_complement_pin_en & ~clock_true_pin_en) == 12'h000)
		else $error("complement on alone");
	a_ext_off: assert property (1 |=> (clock_true_pin_en & $past(ext_disable)) == 12'h000)
		else $error("other source ignored");
	a_hold_true: assert property ($past(rst_b) && !avs_write && !$past(avs_write) && $stable(ext_disable)
		|=> $stable(clock_true_pin_en))
		else $error("enable moved");
	a_read_wait: assert property ($rose(avs_read) |-> avs_waitrequest ##1 !avs_waitrequest)
		else $error("read timing");
	a_resv_zero: assert property (avs_read && !avs_waitrequest && avs_address == 4'h0 |-> avs_readdata[31:13] == 19'h0)
		else $error("reserved not zero");
	a_unmap_zero: assert property (avs_read && !avs_waitrequest && avs_address == 4'hC |-> avs_readdata == 32'h0)
		else $error("unmapped not zero");
	a_stat_match: assert property (avs_read && !avs_waitrequest && avs_address == 4'h8
		|-> avs_readdata[11:0] == $past(clock_true_pin_en) && avs_readdata[27:16] == $past(clock_complement_pin_en))
		else $error("status mismatch");
endmodule
bind ocec_top ocec_top_checker u_chk (.*);

// *** sim/ocec_top_bench.sv ***
// bench: register access and driver enable checks
`timescale 1ns/1ps
module ocec_top_bench;
	logic sys_clk = 0, rst_b = 0, avs_read = 0, avs_write = 0, avs_waitrequest;
	logic [3:0] avs_address = 4'h0;
	logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
	logic [11:0] ext_disable = 12'h000, clock_true_pin_en, clock_complement_pin_en;
	int error_cnt = 0, checks = 0, cyc = 0;
	ocec_top dut (
		.sys_clk(sys_clk),
		.rst_b(rst_b),
		.avs_address(avs_address),
		.avs_read(avs_read),
		.avs_write(avs_write),
		.avs_writedata(avs_writedata),
		.avs_byteenable(4'hF),
		.avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest),
		.ext_disable(ext_disable),
		.clock_true_pin_en(clock_true_pin_en),
		.clock_complement_pin_en(clock_complement_pin_en)
	);
	initial forever #5 sys_clk = ~sys_clk;
	task automatic cmp(input string n, input logic [31:0] s, input logic [31:0] e);
		checks++;
		if (s !== e)
		begin
			error_cnt++;
			$display("[FAIL] %s expected %h seen %h", n, e, s);
		end
	endtask
	// one bus cycle; held until an edge sees waitrequest low, then two idle edges so enables settle
	task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
		avs_write <= w;
		avs_read <= !w;
		avs_address <= a;
		avs_writedata <= d;
		do @(posedge sys_clk); while (avs_waitrequest);
		q = avs_readdata;
		avs_write <= 0;
		avs_read <= 0;
		repeat (2) @(posedge sys_clk);
	endtask
	task automatic t_reset;
		bus(0, 4'h0, 0);
		cmp("ctrl", q, 32'h0000_1000);
		cmp("true", clock_true_pin_en, 32'h0000_0FFF);
		cmp("comp", clock_complement_pin_en, 32'h0);
	endtask
	task automatic t_disable;
		bus(1, 4'h0, 32'h0000_FFE0);
		bus(0, 4'h0, 0);
		cmp("ctrl", q, 32'h0000_1FE0);
		cmp("true", clock_true_pin_en, 32'h0000_001F);
		bus(1, 4'h0, 32'h0000_101F);
		cmp("true", clock_true_pin_en, 32'h0000_0FE0);
		bus(1, 4'h0, 32'h0000_0000);
		cmp("true", clock_true_pin_en, 32'h0);
	endtask
	// differential pairs, other sources, status and an unmapped place
	task automatic t_diff;
		ext_disable <= 12'h004;
		bus(1, 4'h4, 32'h0000_0FFF);
		bus(1, 4'h0, 32'h0000_1801);
		cmp("comp", clock_complement_pin_en, 32'h0000_07FA);
		bus(0, 4'h8, 0);
		cmp("stat", q, 32'h07FA_07FA);
		bus(1, 4'h4, 32'h0000_000F);
		cmp("comp", clock_complement_pin_en, 32'h0000_000A);
		bus(0, 4'h4, 0);
		cmp("mode", q, 32'h0000_000F);
		bus(1, 4'hC, 32'h0000_FFFF);
		bus(0, 4'hC, 0);
		cmp("unmap", q, 32'h0);
		bus(0, 4'h0, 0);
		cmp("ctrl", q, 32'h0000_1801);
	endtask
	task automatic complete_run;
		$display("checks %0d errors %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	initial
	begin
		repeat (2) @(posedge sys_clk);
		rst_b <= 1;
		@(posedge sys_clk);
		t_reset;
		t_disable;
		t_diff;
		complete_run;
	end
	// hang guard
	always @(posedge sys_clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 2000)
		begin
			error_cnt++;
			complete_run;
		end
	end
endmodule
